//--- rtl/nand_host_map.vh
`ifndef NAND_HOST_MAP_VH
`define NAND_HOST_MAP_VH

// array geometry
`define PAGE_COLS_X8    12'd2112
`define PAGE_COLS_X16   12'd1056
`define MAIN_COLS_X8    12'd2048
`define MAIN_COLS_X16   12'd1024
`define PAGES_PER_BLOCK 64
`define BLOCK_COUNT     2048
`define PAGE_COUNT      262144

// command codes
`define CMD_READ_SETUP  8'h00
`define CMD_READ_GO     8'h30
`define CMD_CB_READ_GO  8'h35
`define CMD_READ_ID     8'h90
`define CMD_RESET       8'hff
`define CMD_PROG_SETUP  8'h80
`define CMD_PROG_GO     8'h10
`define CMD_CACHE_GO    8'h15
`define CMD_CB_SETUP    8'h85
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_GO    8'hd0
`define CMD_RND_IN      8'h85
`define CMD_RND_OUT     8'h05
`define CMD_RND_OUT_GO  8'he0
`define CMD_STATUS      8'h70

// user operation codes
`define OP_READ      4'h0
`define OP_CB_READ   4'h1
`define OP_READ_ID   4'h2
`define OP_RESET     4'h3
`define OP_PROGRAM   4'h4
`define OP_CACHE     4'h5
`define OP_CB_PROG   4'h6
`define OP_ERASE     4'h7
`define OP_RND_IN    4'h8
`define OP_RND_OUT   4'h9
`define OP_STATUS    4'ha
`define OP_AUTO_READ 4'hb

// operation table field positions
`define CF_VALID  27
`define CF_CODE1  26:19
`define CF_CODE2  18:11
`define CF_HAS2   10
`define CF_NOADDR 9
`define CF_AFIRST 8:6
`define CF_ALAST  5:3
`define CF_DIN    2
`define CF_DOUT   1
`define CF_WAIT   0

// strobe timing, 8 bits wide so the counts fit the 8-bit counters
`define CLK_NS      8'd10
`define WE_LOW_NS   8'd30
`define WE_HIGH_NS  8'd20
`define RE_LOW_NS   8'd60
`define RE_HIGH_NS  8'd20
`define WB_NS       8'd100
`define WE_LOW_CYC  ((`WE_LOW_NS + `CLK_NS - 8'd1) / `CLK_NS)
`define WE_HIGH_CYC ((`WE_HIGH_NS + `CLK_NS - 8'd1) / `CLK_NS)
`define RE_LOW_CYC  ((`RE_LOW_NS + `CLK_NS - 8'd1) / `CLK_NS)
`define RE_HIGH_CYC ((`RE_HIGH_NS + `CLK_NS - 8'd1) / `CLK_NS)
`define WB_CYC      ((`WB_NS + `CLK_NS - 8'd1) / `CLK_NS)

`endif

//--- rtl/pin_sync3.v
`timescale 1ns/1ps
module pin_sync3 #(
  parameter W = 1
) (
  input  wire         core_clk_i,
  input  wire         reset_i,
  input  wire [W-1:0] pin_i,
  output reg  [W-1:0] level_o
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // three stages; a change counts once stages two and three agree
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      s1_r    <= {W{1'b0}};
      s2_r    <= {W{1'b0}};
      s3_r    <= {W{1'b0}};
      level_o <= {W{1'b0}};
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_o <= s3_r;
    end
  end

endmodule

//--- rtl/nand_host.v
// Functional notes
// - read/program whole pages, erase whole blocks
// - items strobed by write strobe, select low
// - read, program, erase use setup plus execute
// - five address cycles, column then row
// - read and program send all five cycles
// - erase sends only three row cycles
// - x8 address layout, unused lines low
// - x16 address on low lines, upper low
// - while busy only reset and status
// - defined codes only; random access within page
`timescale 1ns/1ps
`include "nand_host_map.vh"
module nand_host (
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire        cmd_valid_i,
  input  wire [3:0]  cmd_op_i,
  input  wire [29:0] cmd_addr_i,
  input  wire [11:0] cmd_len_i,
  input  wire        bus16_i,
  input  wire        protect_i,
  input  wire [15:0] wr_data_i,
  input  wire        wr_valid_i,
  input  wire [15:0] io_i,
  input  wire        ready_busy_i,
  output reg         cmd_ready_o,
  output reg         done_o,
  output reg         err_o,
  output reg         wr_ready_o,
  output reg  [15:0] rd_data_o,
  output reg         rd_valid_o,
  output reg         ce_n_o,
  output reg         cle_o,
  output reg         ale_o,
  output reg         we_n_o,
  output reg         output_strobe_n_o,
  output reg         wp_n_o,
  output reg  [15:0] io_o,
  output reg         io_oe_o
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_CMD1 = 7'h02;
  localparam [6:0] S_ADDR = 7'h04;
  localparam [6:0] S_DIN  = 7'h08;
  localparam [6:0] S_CMD2 = 7'h10;
  localparam [6:0] S_WAIT = 7'h20;
  localparam [6:0] S_DOUT = 7'h40;

  localparam [7:0] WE_LOW_C  = `WE_LOW_CYC;
  localparam [7:0] WE_HIGH_C = `WE_HIGH_CYC;
  localparam [7:0] RE_LOW_C  = `RE_LOW_CYC;
  localparam [7:0] RE_HIGH_C = `RE_HIGH_CYC;
  localparam [7:0] WB_C      = `WB_CYC;

  // one table entry
  function [27:0] mk;
    input [7:0] c1;
    input [7:0] c2;
    input       has2;
    input       noaddr;
    input [2:0] af;
    input [2:0] al;
    input       din;
    input       dout;
    input       wt;
    begin
      mk = {1'b1, c1, c2, has2, noaddr, af, al, din, dout, wt};
    end
  endfunction

  // operation table: codes, address cycles, data phases, busy wait
  function [27:0] op_cfg;
    input [3:0] op;
    begin
      case (op)
        `OP_READ:      op_cfg = mk(`CMD_READ_SETUP, `CMD_READ_GO,
                                   1'b1, 1'b0, 3'd0, 3'd4, 1'b0, 1'b1,
                                   1'b1);
        `OP_CB_READ:   op_cfg = mk(`CMD_READ_SETUP, `CMD_CB_READ_GO,
                                   1'b1, 1'b0, 3'd0, 3'd4, 1'b0, 1'b0,
                                   1'b1);
        `OP_READ_ID:   op_cfg = mk(`CMD_READ_ID, 8'h00, 1'b0, 1'b0,
                                   3'd0, 3'd0, 1'b0, 1'b1, 1'b0);
        `OP_RESET:     op_cfg = mk(`CMD_RESET, 8'h00, 1'b0, 1'b1,
                                   3'd0, 3'd0, 1'b0, 1'b0, 1'b1);
        `OP_PROGRAM:   op_cfg = mk(`CMD_PROG_SETUP, `CMD_PROG_GO,
                                   1'b1, 1'b0, 3'd0, 3'd4, 1'b1, 1'b0,
                                   1'b1);
        `OP_CACHE:     op_cfg = mk(`CMD_PROG_SETUP, `CMD_CACHE_GO,
                                   1'b1, 1'b0, 3'd0, 3'd4, 1'b1, 1'b0,
                                   1'b1);
        `OP_CB_PROG:   op_cfg = mk(`CMD_CB_SETUP, `CMD_PROG_GO,
                                   1'b1, 1'b0, 3'd0, 3'd4, 1'b1, 1'b0,
                                   1'b1);
        `OP_ERASE:     op_cfg = mk(`CMD_ERASE_SETUP, `CMD_ERASE_GO,
                                   1'b1, 1'b0, 3'd2, 3'd4, 1'b0, 1'b0,
                                   1'b1);
        `OP_RND_IN:    op_cfg = mk(`CMD_RND_IN, 8'h00, 1'b0, 1'b0,
                                   3'd0, 3'd1, 1'b1, 1'b0, 1'b0);
        `OP_RND_OUT:   op_cfg = mk(`CMD_RND_OUT, `CMD_RND_OUT_GO,
                                   1'b1, 1'b0, 3'd0, 3'd1, 1'b0, 1'b1,
                                   1'b0);
        `OP_STATUS:    op_cfg = mk(`CMD_STATUS, 8'h00, 1'b0, 1'b1,
                                   3'd0, 3'd0, 1'b0, 1'b1, 1'b0);
        `OP_AUTO_READ: op_cfg = {1'b1, 27'h0000002};
        default:       op_cfg = 28'h0000000;
      endcase
    end
  endfunction

  // one address byte for cycle i, upper lines always low
  function [7:0] addr_byte;
    input [29:0] a;
    input [2:0]  i;
    input        x16;
    begin
      case (i)
        3'd0:    addr_byte = a[7:0];
        3'd1:    addr_byte = x16 ? {5'h00, a[10:8]}
                                 : {4'h0, a[11:8]};
        3'd2:    addr_byte = x16 ? a[18:11] : a[19:12];
        3'd3:    addr_byte = x16 ? a[26:19] : a[27:20];
        3'd4:    addr_byte = x16 ? {6'h00, a[28:27]}
                                 : {6'h00, a[29:28]};
        default: addr_byte = 8'h00;
      endcase
    end
  endfunction

  reg [6:0]  state_r;
  reg [1:0]  ph_r;
  reg [7:0]  cnt_r;
  reg [2:0]  aidx_r;
  reg [11:0] left_r;
  reg [29:0] addr_r;
  reg [15:0] data_r;
  reg [7:0]  code1_r;
  reg [7:0]  code2_r;
  reg        has2_r;
  reg        noaddr_r;
  reg [2:0]  alast_r;
  reg        din_r;
  reg        dout_r;
  reg        wait_r;
  reg        x16_r;
  reg        adv;
  reg [6:0]  target;

  wire [16:0] synced;
  wire        rb_ready = synced[16];
  wire [27:0] cfg      = op_cfg(cmd_op_i);
  wire [11:0] cols     = bus16_i ? `PAGE_COLS_X16 : `PAGE_COLS_X8;
  wire        col_bad  = (bus16_i ? {1'b0, cmd_addr_i[10:0]}
                                  : cmd_addr_i[11:0]) >= cols;
  wire        busy_ok  = rb_ready || cmd_op_i == `OP_RESET ||
                         cmd_op_i == `OP_STATUS;
  wire        refuse   = !cfg[`CF_VALID] || !busy_ok || cmd_len_i > cols ||
                         (!cfg[`CF_NOADDR] && col_bad);
  wire        wrcyc    = (state_r & (S_CMD1 | S_ADDR | S_DIN | S_CMD2)) != 0;
  wire        wend     = wrcyc && ph_r == 2'd1 && cnt_r == WE_HIGH_C - 8'd1;
  wire        rend     = ph_r == 2'd1 && cnt_r == RE_HIGH_C - 8'd1;
  wire [6:0]  s_aw     = dout_r ? S_DOUT : S_IDLE;
  wire [6:0]  s_ac2    = wait_r ? S_WAIT : s_aw;
  wire [6:0]  s_adin   = has2_r ? S_CMD2 : s_ac2;
  wire [6:0]  s_aaddr  = din_r ? S_DIN : s_adin;
  wire [6:0]  s_ac1    = noaddr_r ? s_aaddr : S_ADDR;

  // ready/busy and data lines cross in from the pins
  pin_sync3 #(
    .W (17)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .pin_i      ({ready_busy_i, io_i}),
    .level_o    (synced)
  );

  // sequence step decision
  always @* begin
    adv    = 1'b0;
    target = state_r;
    case (state_r)
      S_CMD1: if (wend) begin
        adv    = 1'b1;
        target = s_ac1;
      end
      S_ADDR: if (wend && aidx_r == alast_r) begin
        adv    = 1'b1; // no surplus address cycles
        target = s_aaddr;
      end
      S_DIN: if (wend && left_r == 12'd1) begin
        adv    = 1'b1;
        target = s_adin;
      end
      S_CMD2: if (wend) begin
        adv    = 1'b1;
        target = s_ac2;
      end
      S_WAIT: if (cnt_r == WB_C && rb_ready) begin
        adv    = 1'b1; // wait time passed and ready seen
        target = s_aw;
      end
      S_DOUT: if (rend && left_r == 12'd1) begin
        adv    = 1'b1;
        target = S_IDLE;
      end
      default: begin
        adv    = 1'b0;
        target = state_r;
      end
    endcase
  end

  // sequencer
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r     <= S_IDLE;
      ph_r        <= 2'd0;
      cnt_r       <= 8'h00;
      aidx_r      <= 3'd0;
      left_r      <= 12'h000;
      addr_r      <= 30'h00000000;
      data_r      <= 16'h0000;
      code1_r     <= 8'h00;
      code2_r     <= 8'h00;
      has2_r      <= 1'b0;
      noaddr_r    <= 1'b0;
      alast_r     <= 3'd0;
      din_r       <= 1'b0;
      dout_r      <= 1'b0;
      wait_r      <= 1'b0;
      x16_r       <= 1'b0;
      cmd_ready_o <= 1'b1;
      done_o      <= 1'b0;
      err_o       <= 1'b0;
      wr_ready_o  <= 1'b0;
      rd_data_o   <= 16'h0000;
      rd_valid_o  <= 1'b0;
    end else begin
      done_o     <= 1'b0;
      err_o      <= 1'b0;
      rd_valid_o <= 1'b0;
      if (state_r == S_IDLE) begin
        if (cmd_valid_i && cmd_ready_o) begin
          if (refuse) begin
            err_o <= 1'b1;
          end else begin
            cmd_ready_o <= 1'b0;
            code1_r     <= cfg[`CF_CODE1];
            code2_r     <= cfg[`CF_CODE2];
            has2_r      <= cfg[`CF_HAS2];
            noaddr_r    <= cfg[`CF_NOADDR];
            aidx_r      <= cfg[`CF_AFIRST];
            alast_r     <= cfg[`CF_ALAST];
            din_r       <= cfg[`CF_DIN] && cmd_len_i != 12'h000;
            dout_r      <= cfg[`CF_DOUT] && cmd_len_i != 12'h000;
            wait_r      <= cfg[`CF_WAIT];
            addr_r      <= cmd_addr_i;
            left_r      <= cmd_len_i;
            x16_r       <= bus16_i;
            ph_r        <= 2'd0;
            cnt_r       <= 8'h00;
            state_r     <= (cmd_op_i == `OP_AUTO_READ) ? S_DOUT
                                                       : S_CMD1;
          end
        end
      end else if (adv) begin
        state_r     <= target;
        cnt_r       <= 8'h00;
        ph_r        <= (target == S_DIN) ? 2'd2 : 2'd0;
        wr_ready_o  <= target == S_DIN;
        cmd_ready_o <= target == S_IDLE;
        done_o      <= target == S_IDLE;
        if (target == S_DOUT && state_r != S_DIN)
          left_r <= left_r;
      end else if (state_r == S_WAIT) begin
        if (cnt_r != WB_C)
          cnt_r <= cnt_r + 8'd1;
      end else if (ph_r == 2'd2) begin
        if (wr_valid_i && wr_ready_o) begin
          data_r     <= x16_r ? wr_data_i : {8'h00, wr_data_i[7:0]};
          wr_ready_o <= 1'b0;
          ph_r       <= 2'd0;
        end
      end else if (ph_r == 2'd0) begin
        if (cnt_r == (wrcyc ? WE_LOW_C : RE_LOW_C) - 8'd1) begin
          cnt_r <= 8'h00;
          ph_r  <= 2'd1;
          if (!wrcyc) begin
            rd_data_o  <= x16_r ? synced[15:0]
                                : {8'h00, synced[7:0]};
            rd_valid_o <= 1'b1;
          end
        end else begin
          cnt_r <= cnt_r + 8'd1;
        end
      end else if (wend || rend) begin
        cnt_r <= 8'h00;
        if (state_r == S_ADDR) begin
          aidx_r <= aidx_r + 3'd1;
          ph_r   <= 2'd0;
        end else if (state_r == S_DIN) begin
          left_r     <= left_r - 12'd1;
          ph_r       <= 2'd2;
          wr_ready_o <= 1'b1;
        end else begin
          left_r <= left_r - 12'd1;
          ph_r   <= 2'd0;
        end
      end else begin
        cnt_r <= cnt_r + 8'd1;
      end
    end
  end

  // pin drivers follow the sequencer one cycle later
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      ce_n_o            <= 1'b1;
      cle_o             <= 1'b0;
      ale_o             <= 1'b0;
      we_n_o            <= 1'b1;
      output_strobe_n_o <= 1'b1;
      wp_n_o            <= 1'b0;
      io_o              <= 16'h0000;
      io_oe_o           <= 1'b0;
    end else begin
      ce_n_o            <= state_r == S_IDLE;
      cle_o             <= (state_r & (S_CMD1 | S_CMD2)) != 0;
      ale_o             <= state_r == S_ADDR;
      we_n_o            <= !(wrcyc && ph_r == 2'd0);
      output_strobe_n_o <= !(state_r == S_DOUT && ph_r == 2'd0);
      wp_n_o            <= !protect_i;
      io_oe_o           <= wrcyc;
      case (state_r)
        S_CMD1:  io_o <= {8'h00, code1_r};
        S_CMD2:  io_o <= {8'h00, code2_r};
        S_ADDR:  io_o <= {8'h00, addr_byte(addr_r, aidx_r, x16_r)};
        S_DIN:   io_o <= data_r;
        default: io_o <= 16'h0000;
      endcase
    end
  end

endmodule

//--- tb/nand_host_assertions.sv
`timescale 1ns/1ps
module nand_host_assertions (
  input wire        core_clk_i,
  input wire        reset_i,
  input wire        protect_i,
  input wire        cmd_ready_o,
  input wire        done_o,
  input wire        err_o,
  input wire        ce_n_o,
  input wire        cle_o,
  input wire        ale_o,
  input wire        we_n_o,
  input wire        output_strobe_n_o,
  input wire        wp_n_o,
  input wire [15:0] io_o,
  input wire        io_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // write strobe shape and qualifiers
  AST_WE_LOW: assert property ($fell(we_n_o) |-> !we_n_o [*3] ##1 we_n_o)
    else $error("write strobe low phase wrong");
  AST_WE_HIGH: assert property ($rose(we_n_o) |-> we_n_o [*2])
    else $error("write strobe high phase short");
  AST_WE_SEL: assert property (!we_n_o |-> !ce_n_o && io_oe_o)
    else $error("write strobe without select or drive");
  AST_LATCH_EXCL: assert property (!we_n_o |-> !(cle_o && ale_o))
    else $error("command and address latch both high");
  AST_UPPER_LOW: assert property (!we_n_o && (cle_o || ale_o) |-> io_o[15:8] == 8'h00)
    else $error("upper lines not low on command or address");
  // read strobe shape and bus release
  AST_RD_LOW: assert property ($fell(output_strobe_n_o) |-> !output_strobe_n_o [*6] ##1 output_strobe_n_o)
    else $error("read strobe low phase wrong");
  AST_RD_BUS: assert property (!output_strobe_n_o |-> !ce_n_o && !io_oe_o && we_n_o)
    else $error("read strobe while driving lines");
  AST_WP: assert property (!$past(reset_i) |-> wp_n_o == !$past(protect_i))
    else $error("lockout pin does not follow protect");
  AST_ERR_IDLE: assert property (err_o |-> cmd_ready_o && ce_n_o ##1 !err_o)
    else $error("refusal touched the pins");
  AST_DONE_RDY: assert property (done_o |-> cmd_ready_o ##1 !done_o)
    else $error("done without ready");
  // main scenarios seen
  cover property ($fell(output_strobe_n_o));
  cover property (err_o);
  cover property (!we_n_o && ale_o);
  cover property (done_o);
endmodule
bind nand_host nand_host_assertions chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .protect_i(protect_i),
  .cmd_ready_o(cmd_ready_o), .done_o(done_o), .err_o(err_o),
  .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o),
  .output_strobe_n_o(output_strobe_n_o), .wp_n_o(wp_n_o), .io_o(io_o),
  .io_oe_o(io_oe_o));

//--- tb/nand_dev_model.sv
`timescale 1ns/1ps
module nand_dev_model #(
  parameter [7:0] STATUS_BYTE = 8'h40,
  parameter       BUSY_NS     = 300
) (
  input  wire        ce_n_i,
  input  wire        cle_i,
  input  wire        ale_i,
  input  wire        we_n_i,
  input  wire        strobe_n_i,
  input  wire        wp_n_i,
  input  wire        x16_i,
  input  wire        hold_busy_i,
  input  wire [15:0] io_i,
  output reg  [15:0] io_o = 16'h0000,
  output wire        ready_busy_o
);
  reg [7:0] cmd_log [0:7];
  reg [7:0] adr_log [0:7];
  reg [7:0] din_log [0:7];
  reg [7:0] c;
  reg       busy_r  = 1'b0;
  reg       upper_r = 1'b0;
  reg       stat_r  = 1'b0;
  integer   cmd_n = 0, adr_n = 0, din_n = 0;
  integer   col = 0; // serial readout from column 0 at power-up
  // busy while an operation runs or the bench holds it
  assign ready_busy_o = !busy_r && !hold_busy_i;
  // capture on write strobe rise while selected
  always @(posedge we_n_i) if (!ce_n_i) begin
    c = io_i[7:0];
    if (io_i[15:8] != 8'h00 && (cle_i || ale_i)) upper_r = 1'b1;
    if (cle_i) begin
      cmd_log[cmd_n % 8] = c;
      cmd_n = cmd_n + 1;
      stat_r = (c == 8'h70);
      // column start from the two column cycles
      if (c == 8'h30 || c == 8'h35 || c == 8'he0)
        col = {adr_log[1] & (x16_i ? 8'h07 : 8'h0f), adr_log[0]};
      if ((c == 8'h10 || c == 8'h15 || c == 8'hd0) && !wp_n_i) c = 8'h00;
      // execute codes start an array operation
      case (c)
        8'h30, 8'h35, 8'h10, 8'h15, 8'hd0, 8'hff: begin
          busy_r = 1'b1;
          busy_r <= #(BUSY_NS) 1'b0;
        end
        default: ;
      endcase
    end else if (ale_i) begin
      if (adr_n < 8) adr_log[adr_n] = c; // surplus cycles dropped
      adr_n = adr_n + 1;
    end else begin
      din_log[din_n % 8] = c;
      din_n = din_n + 1;
    end
  end
  // each strobe fall puts the next column out, or the status byte after a status command
  always @(negedge strobe_n_i) if (!ce_n_i) begin
    io_o = stat_r ? {8'h00, STATUS_BYTE} : {col[7:0] ^ 8'ha5, col[7:0] ^ 8'h5a};
    col = col + 1;
  end
  // released lines show the inverse of the last item
  always @(posedge strobe_n_i) io_o = ~io_o;
endmodule

//--- tb/nand_host_bench.sv
`timescale 1ns/1ps
module nand_host_bench;
  reg         core_clk_i  = 1'b0;
  reg         reset_i     = 1'b1;
  reg         cmd_valid_i = 1'b0;
  reg  [3:0]  cmd_op_i    = 4'h0;
  reg  [29:0] cmd_addr_i  = 30'h0;
  reg  [11:0] cmd_len_i   = 12'h0;
  reg         bus16_i     = 1'b0;
  reg         protect_i   = 1'b0;
  reg  [15:0] wr_data_i   = 16'h0;
  reg         wr_valid_i  = 1'b1;
  reg         hold_busy   = 1'b0;
  reg         saw_err;
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     cycles      = 0;
  reg  [15:0] rd_q [$];
  wire [15:0] io_o, dev_io, rd_data_o;
  wire        cmd_ready_o, done_o, err_o, wr_ready_o, rd_valid_o, ready_busy_i;
  wire        ce_n_o, cle_o, ale_o, we_n_o, output_strobe_n_o, wp_n_o, io_oe_o;
  wire [15:0] io_i = io_oe_o ? io_o : dev_io;

  nand_host uut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
    .bus16_i(bus16_i), .protect_i(protect_i), .wr_data_i(wr_data_i),
    .wr_valid_i(wr_valid_i), .io_i(io_i), .ready_busy_i(ready_busy_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .err_o(err_o),
    .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .ce_n_o(ce_n_o), .cle_o(cle_o),
    .ale_o(ale_o), .we_n_o(we_n_o),
    .output_strobe_n_o(output_strobe_n_o), .wp_n_o(wp_n_o), .io_o(io_o),
    .io_oe_o(io_oe_o));
  nand_dev_model dev (
    .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o),
    .strobe_n_i(output_strobe_n_o), .wp_n_i(wp_n_o), .x16_i(bus16_i),
    .hold_busy_i(hold_busy), .io_i(io_i), .io_o(dev_io),
    .ready_busy_o(ready_busy_i));

  // free-running clock
  initial forever #5 core_clk_i = ~core_clk_i;
  // cycle ceiling against hangs
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end
  // collect read words, feed write words
  always @(negedge core_clk_i) if (rd_valid_o === 1'b1) rd_q.push_back(rd_data_o);
  // write valid drops every other cycle so the data phase also stalls
  always @(posedge core_clk_i) begin
    wr_valid_i <= ~wr_valid_i;
    if (wr_ready_o === 1'b1 && wr_valid_i === 1'b1)
      wr_data_i <= wr_data_i + 16'h1;
  end

  task give_verdict;
    begin
      if (miscompares == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task run_op(input [3:0] op, input [29:0] a, input [11:0] n, input x16);
    integer k;
    begin
      dev.cmd_n = 0;
      dev.adr_n = 0;
      dev.din_n = 0;
      dev.upper_r = 1'b0;
      rd_q.delete();
      saw_err = 1'b0;
      cmd_op_i <= op;
      cmd_addr_i <= a;
      cmd_len_i <= n;
      bus16_i <= x16;
      cmd_valid_i <= 1'b1;
      @(negedge core_clk_i);
      while (cmd_ready_o !== 1'b1) @(negedge core_clk_i);
      @(posedge core_clk_i);
      cmd_valid_i <= 1'b0;
      for (k = 0; k < 5000; k = k + 1) begin
        @(negedge core_clk_i);
        if (err_o === 1'b1) saw_err = 1'b1;
        if (done_o === 1'b1 || err_o === 1'b1) k = 5000;
      end
      if (k == 5000) begin // operation never ended
        miscompares = miscompares + 1;
        give_verdict;
      end
      @(posedge core_clk_i);
    end
  endtask

  task chk_seq(input [3:0] nc, input [7:0] c0, input [7:0] c1, input [3:0] na);
    begin
      chk("cmd count", nc, dev.cmd_n);
      chk("first cmd", c0, dev.cmd_log[0]);
      if (nc > 1) chk("second cmd", c1, dev.cmd_log[1]);
      chk("addr count", na, dev.adr_n);
    end
  endtask

  task chk_adr(input [39:0] b, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) chk("addr byte", b[8*i +: 8], dev.adr_log[i]);
    end
  endtask

  task t_auto;
    begin
      run_op(4'hb, 30'h0, 12'd2, 1'b0);
      chk("auto cmds", 16'h0, dev.cmd_n);
      chk("auto d0", 16'h005a, rd_q[0]);
      chk("auto d1", 16'h005b, rd_q[1]);
    end
  endtask

  task t_status_reset;
    begin
      run_op(4'ha, 30'h0, 12'd1, 1'b0);
      chk_seq(4'd1, 8'h70, 8'h00, 4'd0);
      chk("status", 16'h0040, rd_q[0]);
      run_op(4'h3, 30'h0, 12'd0, 1'b0);
      chk_seq(4'd1, 8'hff, 8'h00, 4'd0);
      chk("ready after", 16'h1, ready_busy_i);
    end
  endtask

  task t_read;
    begin
      run_op(4'h0, {18'h2c3a5, 12'h83e}, 12'd2, 1'b0);
      chk_seq(4'd2, 8'h00, 8'h30, 4'd5);
      chk_adr(40'h02c3a5083e, 5);
      chk("spare d0", 16'h0064, rd_q[0]);
      chk("spare d1", 16'h0065, rd_q[1]);
      run_op(4'h0, {1'b0, 18'h2b1c9, 11'h41f}, 12'd1, 1'b1);
      chk_adr(40'h02b1c9041f, 5);
      chk("upper lines", 16'h0, dev.upper_r);
      chk("word", 16'hba45, rd_q[0]);
    end
  endtask

  task t_erase_prog;
    begin
      run_op(4'h7, {18'h2c3a5, 12'h000}, 12'd0, 1'b0);
      chk_seq(4'd2, 8'h60, 8'hd0, 4'd3);
      chk_adr(40'h02c3a5, 3);
      wr_data_i <= 16'h1234;
      run_op(4'h4, {18'h00041, 12'h004}, 12'd2, 1'b0);
      chk_seq(4'd2, 8'h80, 8'h10, 4'd5);
      chk_adr(40'h0000410004, 5);
      chk("data count", 16'd2, dev.din_n);
      chk("data 0", 16'h0034, dev.din_log[0]);
      chk("data 1", 16'h0035, dev.din_log[1]);
    end
  endtask

  // op, cmd count, addr count, len, first, second code
  localparam [191:0] TAB = {32'h5251_8015, 32'h1250_0035, 32'h6250_8510,
                            32'h2111_9000, 32'h9221_05e0, 32'h8121_8500};
  task t_table;
    integer i;
    reg [31:0] e;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        e = TAB[32*i +: 32];
        run_op(e[31:28], {18'h00041, 12'h010}, {8'h00, e[19:16]}, 1'b0);
        chk_seq(e[27:24], e[15:8], e[7:0], e[23:20]);
      end
    end
  endtask

  task t_refuse;
    begin
      run_op(4'hc, 30'h0, 12'd0, 1'b0);
      chk("bad op", 16'h1, saw_err);
      chk("bad op cmds", 16'h0, dev.cmd_n);
      run_op(4'h0, {18'h1, 12'd2112}, 12'd1, 1'b0);
      chk("column past page", 16'h1, saw_err);
      run_op(4'h0, 30'h0, 12'd2113, 1'b0);
      chk("length past page", 16'h1, saw_err);
      hold_busy <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      run_op(4'h0, 30'h0, 12'd1, 1'b0);
      chk("read while busy", 16'h1, saw_err);
      run_op(4'ha, 30'h0, 12'd1, 1'b0);
      chk("status while busy", 16'h0, saw_err);
      chk_seq(4'd1, 8'h70, 8'h00, 4'd0);
      hold_busy <= 1'b0;
      repeat (6) @(posedge core_clk_i);
    end
  endtask

  task t_protect;
    begin
      protect_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      chk("lockout on", 16'h0, wp_n_o);
      protect_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      chk("lockout off", 16'h1, wp_n_o);
    end
  endtask

  // reset, then every scenario in turn
  initial begin
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    t_auto;
    t_status_reset;
    t_read;
    t_erase_prog;
    t_table;
    t_refuse;
    t_protect;
    give_verdict;
  end
endmodule
